// ===== inc/pes_pkg.sv
// constants and types for the receive elastic buffer and status block
package pes_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 50;
  localparam int SYM_PERIOD_NS = 400;
  // one symbol slot on the parallel side, in system clocks
  localparam int READ_DIV = SYM_PERIOD_NS / SYS_PERIOD_NS;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(READ_DIV - 1);
  // latest start of inversion after request, in symbols
  localparam int INV_LATENCY_SYM = 20;

  // ---------------------------------------------------------------
  // elastic buffer geometry and thresholds
  // ---------------------------------------------------------------
  localparam int BUF_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [CNT_W-1:0] CNT_HIGH = 4'h6;
  localparam logic [CNT_W-1:0] CNT_LOW = 4'h3;
  localparam logic [CNT_W-1:0] CNT_MIN_ADD = 4'h2;

  // ---------------------------------------------------------------
  // special symbols (k-codes)
  // ---------------------------------------------------------------
  localparam logic [7:0] K_COM = 8'hbc;
  localparam logic [7:0] K_SKP = 8'h1c;
  localparam logic [7:0] K_EDB = 8'hfe;

  // ---------------------------------------------------------------
  // receive status encoding
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OK       = 3'h0,
    ST_SKP_ADD  = 3'h1,
    ST_SKP_DEL  = 3'h2,
    ST_RX_DET   = 3'h3,
    ST_DEC_ERR  = 3'h4,
    ST_OVERFLOW = 3'h5,
    ST_UNDERFLOW = 3'h6,
    ST_DISP_ERR = 3'h7
  } pesStatus_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic isK;
    logic decErr;
    logic dispErr;
  } pesLinkSym_t;

  typedef struct packed {
    pesLinkSym_t sym;
    logic ovf;
    logic skpDel;
  } pesBufEntry_t;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FILL = 8'h0c;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic CTRL_EN_RST = 1'b1;

endpackage

// ===== core/pes_rx_elastic.sv
// receive elastic buffer, skip compensation, status codes and tx disparity force
//
// Operation
// - the buffer holds eight symbols, more than the seven needed for worst offset.
// - at most one skip symbol is added or removed in any one skip ordered-set.
// - an add or remove shows a non-zero status for one cycle, with the set's comma.
// - a removed skip is still reported with the comma even if no skip is left.
// - status codes are 0 ok, 1 add, 2 remove, 3 detect, 4 decode, 5 over, 6 under, 7 disparity.
// - each receive error shows its code for one cycle at the affected slot, unless a more urgent error shares that slot.
// - only the most urgent error is shown: underflow, decode, overflow, disparity.
// - an undecodable symbol is replaced by the bad-end symbol with the decode code.
// - a disparity error is flagged in the slot that carries the affected byte.
// - an underflow inserts a bad-end symbol and flags it in that same slot.
// - an overflow drops one symbol and flags the slot of the next symbol that is kept.
// - the inversion flag is raised while requested, within twenty symbols; received data is not inverted here.
// - a one-cycle force pulse makes the aligned transmit byte use negative disparity.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module pes_rx_elastic
  import pes_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  // link side, from outside the clock domain
  input wire logic linkClk,
  input wire pesLinkSym_t linkSym,
  input wire logic rxInvertRequest,
  // parallel receive side
  output logic [7:0] rxData_q,
  output logic rxIsK_q,
  output logic rxValid_q,
  output logic [2:0] rxStatusCode_q,
  output logic rxInvertActive_q,
  // transmit side
  input wire logic [7:0] txDataIn,
  input wire logic txNegativeDisparityForce,
  output logic [7:0] txData_q,
  output logic txDispNeg_q,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata_q,
  output logic irq_q
);

  // ---------------------------------------------------------------
  // link input synchronisers
  // ---------------------------------------------------------------
  logic linkClkS1_q, linkClkS2_q, linkClkS3_q;
  pesLinkSym_t symS1_q, symS2_q;
  logic invS1_q;
  logic linkRise;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      linkClkS1_q <= 1'b0;
      linkClkS2_q <= 1'b0;
      linkClkS3_q <= 1'b0;
      symS1_q <= '0;
      symS2_q <= '0;
    end
    else
    begin
      linkClkS1_q <= linkClk;
      linkClkS2_q <= linkClkS1_q;
      linkClkS3_q <= linkClkS2_q;
      symS1_q <= linkSym;
      symS2_q <= symS1_q;
    end
  end

  assign linkRise = linkClkS2_q & ~linkClkS3_q;

  // inversion request reaches the deserialiser in two system clocks
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      invS1_q <= 1'b0;
      rxInvertActive_q <= 1'b0;
    end
    else
    begin
      invS1_q <= rxInvertRequest;
      rxInvertActive_q <= invS1_q;
    end
  end

  // ---------------------------------------------------------------
  // registers and slot divider
  // ---------------------------------------------------------------
  logic [7:0] irqStat_q, irqMask_q;
  logic ctrlEn_q;
  logic [DIV_W-1:0] divCnt_q;
  logic slot;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      divCnt_q <= '0;
    else if (divCnt_q == DIV_LAST)
      divCnt_q <= '0;
    else
      divCnt_q <= divCnt_q + 1'b1;
  end

  assign slot = (divCnt_q == DIV_LAST) & ctrlEn_q;

  // ---------------------------------------------------------------
  // elastic buffer storage and pointers
  // ---------------------------------------------------------------
  pesBufEntry_t mem [BUF_DEPTH];
  logic [PTR_W-1:0] wrPtr_q, rdPtr_q;
  logic [CNT_W-1:0] count_q;
  logic lastWasCom_q, ovfPend_q, insertSkp_q;
  logic wrIsSkp, delSkp, push, pop, overflow;
  pesBufEntry_t head, nextEntry;
  logic headIsCom, nextIsSkp, addSkp;

  assign head = mem[rdPtr_q];
  assign nextEntry = mem[rdPtr_q + 1'b1];
  assign headIsCom = head.sym.isK & (head.sym.data == K_COM) & ~head.sym.decErr;
  assign nextIsSkp = nextEntry.sym.isK & (nextEntry.sym.data == K_SKP);

  assign wrIsSkp = linkRise & symS2_q.isK & (symS2_q.data == K_SKP) & ~symS2_q.decErr;
  // remove only the first skip after the comma, and only while the comma is unread
  assign delSkp = wrIsSkp & lastWasCom_q & (count_q >= CNT_HIGH);
  assign pop = slot & ~insertSkp_q & (count_q != '0);
  assign overflow = linkRise & ~delSkp & (count_q == CNT_FULL) & ~pop;
  assign push = linkRise & ~delSkp & ~overflow;
  // add one skip behind a comma when running low and a skip follows
  assign addSkp = pop & headIsCom & (count_q >= CNT_MIN_ADD) & (count_q <= CNT_LOW)
    & nextIsSkp;

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wrPtr_q] <= '{sym: symS2_q, ovf: ovfPend_q, skpDel: 1'b0};
    if (delSkp)
      mem[wrPtr_q - 1'b1].skpDel <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // skip set tracking and overflow marking
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lastWasCom_q <= 1'b0;
      ovfPend_q <= 1'b0;
    end
    else
    begin
      if (linkRise)
        lastWasCom_q <= push & symS2_q.isK & (symS2_q.data == K_COM) & ~symS2_q.decErr;
      // dropped symbol is flagged on the slot of its successor
      if (overflow)
        ovfPend_q <= 1'b1;
      else if (push)
        ovfPend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status selection for the slot being presented
  // ---------------------------------------------------------------
  pesStatus_t slotStatus;
  logic [7:0] slotData;
  logic slotIsK;

  always_comb
  begin
    slotData = head.sym.data;
    slotIsK = head.sym.isK;
    slotStatus = ST_OK;
    if (insertSkp_q)
    begin
      slotData = K_SKP;
      slotIsK = 1'b1;
    end
    else if (count_q == '0)
    begin
      slotData = K_EDB;
      slotIsK = 1'b1;
      slotStatus = ST_UNDERFLOW;
    end
    else if (head.sym.decErr)
    begin
      slotData = K_EDB;
      slotIsK = 1'b1;
      slotStatus = ST_DEC_ERR;
    end
    else if (head.ovf)
      slotStatus = ST_OVERFLOW;
    else if (head.sym.dispErr)
      slotStatus = ST_DISP_ERR;
    else if (head.skpDel)
      slotStatus = ST_SKP_DEL;
    else if (addSkp)
      slotStatus = ST_SKP_ADD;
  end

  // ---------------------------------------------------------------
  // parallel output, one status per slot
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxData_q <= 8'h00;
      rxIsK_q <= 1'b0;
      rxValid_q <= 1'b0;
      rxStatusCode_q <= ST_OK;
      insertSkp_q <= 1'b0;
    end
    else
    begin
      rxValid_q <= slot;
      if (slot)
      begin
        rxData_q <= slotData;
        rxIsK_q <= slotIsK;
        rxStatusCode_q <= slotStatus;
        insertSkp_q <= addSkp;
      end
      else
        rxStatusCode_q <= ST_OK;
    end
  end

  // ---------------------------------------------------------------
  // transmit disparity force, aligned with its byte
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txData_q <= 8'h00;
      txDispNeg_q <= 1'b0;
    end
    else
    begin
      txData_q <= txDataIn;
      txDispNeg_q <= txNegativeDisparityForce;
    end
  end

  // ---------------------------------------------------------------
  // register file and interrupt
  // ---------------------------------------------------------------
  logic [7:0] statSet;
  logic statClr;

  // bit n of the status register records non-zero status code n
  always_comb
  begin
    statSet = 8'h00;
    if (slot && slotStatus != ST_OK)
      statSet[slotStatus] = 1'b1;
  end

  assign statClr = regRd & (regAddr == REG_IRQ_STAT);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStat_q <= 8'h00;
      irqMask_q <= IRQ_MASK_RST;
      ctrlEn_q <= CTRL_EN_RST;
    end
    else
    begin
      // a new event wins over the read clear
      irqStat_q <= (statClr ? 8'h00 : irqStat_q) | statSet;
      if (regWr && regAddr == REG_IRQ_MASK)
        irqMask_q <= regWdata[7:0];
      if (regWr && regAddr == REG_CTRL)
        ctrlEn_q <= regWdata[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regRdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(irqStat_q & irqMask_q);
      regRdata_q <= 32'h0000_0000;
      if (regRd)
      begin
        case (regAddr)
          REG_IRQ_STAT: regRdata_q <= {24'h000000, irqStat_q};
          REG_IRQ_MASK: regRdata_q <= {24'h000000, irqMask_q};
          REG_CTRL: regRdata_q <= {31'h00000000, ctrlEn_q};
          REG_FILL: regRdata_q <= {28'h0000000, count_q};
          default: regRdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== test/pes_rx_elastic_asserts.sv
// port assertions for the receive elastic block
`timescale 1ns/1ns
`default_nettype none

module pes_rx_elastic_asserts
  import pes_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic rxInvertRequest,
  input wire logic [7:0] rxData_q,
  input wire logic rxIsK_q,
  input wire logic rxValid_q,
  input wire logic [2:0] rxStatusCode_q,
  input wire logic rxInvertActive_q,
  input wire logic [7:0] txDataIn,
  input wire logic txNegativeDisparityForce,
  input wire logic [7:0] txData_q,
  input wire logic txDispNeg_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // slot framing, codes, transmit force alignment and inversion start
  // ----------------------------------------
  code_slot_a: assert property (rxStatusCode_q != 3'h0 |-> rxValid_q)
    else $error("status outside a slot");
  slot_pulse_a: assert property (rxValid_q |=> !rxValid_q)
    else $error("slot longer than one cycle");
  under_edb_a: assert property (rxValid_q && rxStatusCode_q == ST_UNDERFLOW
    |-> rxIsK_q && rxData_q == K_EDB) else $error("underflow without bad-end");
  decode_edb_a: assert property (rxValid_q && rxStatusCode_q == ST_DEC_ERR
    |-> rxIsK_q && rxData_q == K_EDB) else $error("decode error without bad-end");
  skip_com_a: assert property (rxValid_q && rxStatusCode_q inside {ST_SKP_ADD, ST_SKP_DEL}
    |-> rxIsK_q && rxData_q == K_COM) else $error("skip code off the comma");
  add_skp_a: assert property (rxValid_q && rxStatusCode_q == ST_SKP_ADD
    |=> ##7 rxValid_q && rxIsK_q && rxData_q == K_SKP) else $error("added skip missing");
  force_align_a: assert property (txNegativeDisparityForce
    |=> txDispNeg_q && txData_q == $past(txDataIn)) else $error("force not aligned");
  invert_start_a: assert property ($rose(rxInvertRequest)
    |-> ##[1:160] rxInvertActive_q) else $error("inversion late");

  cover property (rxValid_q && rxStatusCode_q == ST_SKP_DEL);
  cover property (rxValid_q && rxStatusCode_q == ST_SKP_ADD);
  cover property (rxValid_q && rxStatusCode_q == ST_OVERFLOW);
endmodule

bind pes_rx_elastic pes_rx_elastic_asserts u_chk (.sys_clk, .arst_n, .rxInvertRequest,
  .rxData_q, .rxIsK_q, .rxValid_q, .rxStatusCode_q, .rxInvertActive_q, .txDataIn,
  .txNegativeDisparityForce, .txData_q, .txDispNeg_q);

`default_nettype wire

// ===== test/pes_link_model.sv
// far end of the lane: sends one decoded symbol per link clock
`timescale 1ns/1ns
`default_nettype none

module pes_link_model
  import pes_pkg::*;
(
  output logic linkClk,
  output pesLinkSym_t linkSym
);
  initial
  begin
    linkClk = 1'b0;
    linkSym = '0;
  end

  // clock stands still between symbols
  task automatic send(input pesLinkSym_t s);
    linkSym = s;
    #200 linkClk = 1'b1;
    #200 linkClk = 1'b0;
    // released lines show the inverse of the last symbol
    linkSym = ~s;
  endtask
endmodule

`default_nettype wire

// ===== test/test_pes_rx_elastic.sv
// self-checking bench for the receive elastic block
`timescale 1ns/1ns
`default_nettype none

module test_pes_rx_elastic
  import pes_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic rxInvertRequest = 1'b0;
  logic [7:0] txDataIn = 8'h00;
  logic txNegativeDisparityForce = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic linkClk;
  pesLinkSym_t linkSym;
  logic [7:0] rxData_q, txData_q;
  logic [2:0] rxStatusCode_q;
  logic rxIsK_q, rxValid_q, rxInvertActive_q, txDispNeg_q, irq_q;
  logic [31:0] regRdata_q, rdv;
  logic [11:0] expQ[$];
  logic [7:0] r;
  logic [8:0] pv;
  int mismatches = 0;
  int tests_run = 0;
  int i;

  always #25 sys_clk = ~sys_clk;

  pes_rx_elastic u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .linkClk(linkClk),
    .linkSym(linkSym), .rxInvertRequest(rxInvertRequest), .rxData_q(rxData_q),
    .rxIsK_q(rxIsK_q), .rxValid_q(rxValid_q), .rxStatusCode_q(rxStatusCode_q),
    .rxInvertActive_q(rxInvertActive_q), .txDataIn(txDataIn),
    .txNegativeDisparityForce(txNegativeDisparityForce), .txData_q(txData_q),
    .txDispNeg_q(txDispNeg_q), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata_q(regRdata_q), .irq_q(irq_q));
  pes_link_model u_link (.linkClk(linkClk), .linkSym(linkSym));
  // scan test reset is no pin of this block; the board keeps it low

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task close_out;
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    idle(1);
    regWr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    idle(1);
    regRd <= 1'b0;
    idle(1);
    rdv = regRdata_q;
  endtask

  // code 3 never leaves the block, so it marks a dropped symbol
  task snd(input logic [10:0] s, input logic [11:0] e);
    if (e[2:0] != ST_RX_DET)
      expQ.push_back(e);
    u_link.send(s);
    idle(1);
  endtask

  // slots: idle ones must be bad-end underflow, others match the oldest note
  always @(posedge sys_clk)
    if (arst_n && rxValid_q === 1'b1)
    begin
      if (rxStatusCode_q === ST_UNDERFLOW || expQ.size() == 0)
        chk({rxData_q, rxIsK_q, rxStatusCode_q}, {K_EDB, 1'b1, ST_UNDERFLOW});
      else
        chk({rxData_q, rxIsK_q, rxStatusCode_q}, expQ.pop_front());
    end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'heb6436c5));
    idle(8);
    arst_n <= 1'b1;
    idle(1);
    rd(REG_CTRL);
    chk(rdv, 32'h1);
    rd(8'h10);
    chk(rdv, 32'h0);
    wr(REG_IRQ_MASK, 32'h4);
    idle(20);
    wr(REG_CTRL, 32'h0);
    idle(16);
    snd({8'h11, 3'b000}, {8'h11, 1'b0, ST_OK});
    snd({8'h22, 3'b011}, {K_EDB, 1'b1, ST_DEC_ERR});
    snd({8'h33, 3'b001}, {8'h33, 1'b0, ST_DISP_ERR});
    for (i = 0; i < 2; i++)
    begin
      r = (8'($urandom) & 8'h3f) | 8'h40;
      snd({r, 3'b000}, {r, 1'b0, ST_OK});
    end
    snd({K_COM, 3'b100}, {K_COM, 1'b1, ST_SKP_DEL});
    snd({K_SKP, 3'b100}, {K_SKP, 1'b1, ST_RX_DET});
    snd({8'h55, 3'b000}, {8'h55, 1'b0, ST_OK});
    snd({8'h66, 3'b000}, {8'h66, 1'b0, ST_OK});
    rd(REG_FILL);
    chk(rdv, 32'h8);
    snd({8'h77, 3'b000}, {8'h77, 1'b0, ST_RX_DET});
    wr(REG_CTRL, 32'h1);
    for (i = 0; i < 40 && rxValid_q !== 1'b1; i++) idle(1);
    chk(rxValid_q, 1'b1);
    r = (8'($urandom) & 8'h3f) | 8'h40;
    snd({r, 3'b001}, {r, 1'b0, ST_OVERFLOW});
    idle(120);
    chk(expQ.size(), 0);
    chk(irq_q, 1'b1);
    rd(REG_IRQ_STAT);
    chk(rdv & 32'h0c, 32'h04);
    idle(3);
    chk(irq_q, 1'b0);
    wr(REG_CTRL, 32'h0);
    idle(16);
    snd({K_COM, 3'b100}, {K_COM, 1'b1, ST_SKP_ADD});
    expQ.push_back({K_SKP, 1'b1, ST_OK});
    snd({K_SKP, 3'b100}, {K_SKP, 1'b1, ST_OK});
    snd({8'h44, 3'b000}, {8'h44, 1'b0, ST_OK});
    wr(REG_CTRL, 32'h1);
    idle(80);
    chk(expQ.size(), 0);
    for (i = 0; i < 12; i++)
    begin
      r = 8'($urandom);
      txDataIn <= r;
      txNegativeDisparityForce <= i[0];
      idle(1);
      if (i > 0)
        chk({txData_q, txDispNeg_q}, pv);
      pv = {r, i[0]};
    end
    txNegativeDisparityForce <= 1'b0;
    rxInvertRequest <= 1'b1;
    for (i = 0; i < 160 && rxInvertActive_q !== 1'b1; i++) idle(1);
    chk(rxInvertActive_q, 1'b1);
    rxInvertRequest <= 1'b0;
    idle(8);
    chk(rxInvertActive_q, 1'b0);
    close_out;
  end
endmodule

`default_nettype wire
